// >>> src/dpdc_controller.sv
`timescale 1ns/10ps
//==============================================================
// controller end: makes the link clock, drives CKE and commands
module dpdc_controller
#(
  parameter logic [15:0] CK_HALF_CYC  = dpdc_pkg::DPDC_CK_HALF_CYC,
  parameter logic [15:0] T_CKE_NCK    = dpdc_pkg::DPDC_T_CKE_NCK,
  parameter logic [15:0] T_CPDED_NCK  = dpdc_pkg::DPDC_T_CPDED_NCK,
  parameter logic [15:0] T_XP_NCK     = dpdc_pkg::DPDC_T_XP_NCK,
  parameter logic [15:0] T_XPDLL_NCK  = dpdc_pkg::DPDC_T_XPDLL_NCK,
  parameter int unsigned PD_MAX_CYC   = dpdc_pkg::DPDC_PD_MAX_CYC
)
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  dpdc_link_if.ctrl        LINK,
  input  wire logic        PD_REQ,
  input  wire logic        BLOCKING_BUSY,
  input  wire logic        DLL_LOCKED,
  input  wire logic        SLOW_EXIT,
  input  wire logic        DRAM_RESET,
  input  wire logic        CMD_VALID,
  input  wire logic [3:0]  CMD_CODE,
  input  wire logic        USER_ODT,
  output logic             CMD_TAKEN,
  output logic             IN_PD,
  output logic             CMD_OK,
  output logic             DLL_CMD_OK,
  output logic             PD_ENTRY_OK,
  output logic             NEED_DLL_RESET
);

  dpdc_pkg::dpdc_ctrl_state_type state_reg;
  logic [15:0]                   div_cnt_reg;
  logic                          ck_reg;
  logic                          launch;
  logic [15:0]                   nck_cnt_reg;
  logic [15:0]                   xpdll_cnt_reg;
  logic [15:0]                   cke_hi_cnt_reg;
  logic [31:0]                   pd_time_reg;
  logic                          slow_reg;
  logic                          unlocked_reg;
  logic                          entry_ok;
  logic                          exit_due;
  logic                          cmd_gate;
  logic                          odt_gate;

  //============================================================
  // link clock divider; launch point on the falling edge
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      div_cnt_reg <= 16'h0000;
      ck_reg      <= 1'h0;
    end
    else if (div_cnt_reg + 16'h0001 >= CK_HALF_CYC)
    begin
      div_cnt_reg <= 16'h0000;
      ck_reg      <= !ck_reg;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  assign launch = ck_reg && (div_cnt_reg + 16'h0001 >= CK_HALF_CYC);

  //============================================================
  // entry, exit, command and termination conditions
  assign entry_ok = PD_REQ && !BLOCKING_BUSY && !DRAM_RESET
                    && cke_hi_cnt_reg >= T_CKE_NCK
                    && (!slow_reg || xpdll_cnt_reg >= T_XPDLL_NCK);

  assign exit_due = nck_cnt_reg >= T_CKE_NCK
                    && (!PD_REQ || pd_time_reg >= PD_MAX_CYC);

  assign cmd_gate = state_reg == dpdc_pkg::CS_RUN && !DRAM_RESET
                    && nck_cnt_reg >= T_XP_NCK;

  assign odt_gate = (!slow_reg || xpdll_cnt_reg >= T_XPDLL_NCK) && !NEED_DLL_RESET;

  //============================================================
  // state and link counter
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      state_reg   <= dpdc_pkg::CS_RUN;
      nck_cnt_reg <= T_XP_NCK;
    end
    else if (DRAM_RESET)
    begin
      state_reg   <= dpdc_pkg::CS_RUN;
      nck_cnt_reg <= 16'h0000;
    end
    else if (launch)
    begin
      case (state_reg)
        dpdc_pkg::CS_RUN:
        begin
          if (entry_ok && !CMD_VALID)
          begin
            state_reg   <= dpdc_pkg::CS_ENTER;
            nck_cnt_reg <= 16'h0000;
          end
          else if (nck_cnt_reg < T_XP_NCK)
          begin
            nck_cnt_reg <= nck_cnt_reg + 16'h0001;
          end
        end
        dpdc_pkg::CS_ENTER:
        begin
          nck_cnt_reg <= nck_cnt_reg + 16'h0001;
          if (nck_cnt_reg + 16'h0001 >= T_CPDED_NCK)
          begin
            state_reg <= dpdc_pkg::CS_PD;
          end
        end
        dpdc_pkg::CS_PD:
        begin
          if (exit_due)
          begin
            state_reg   <= dpdc_pkg::CS_EXIT;
            nck_cnt_reg <= 16'h0000;
          end
          else if (nck_cnt_reg < T_CKE_NCK)
          begin
            nck_cnt_reg <= nck_cnt_reg + 16'h0001;
          end
        end
        dpdc_pkg::CS_EXIT:
        begin
          state_reg   <= dpdc_pkg::CS_RUN;
          nck_cnt_reg <= 16'h0001;
        end
        default:
        begin
          state_reg   <= dpdc_pkg::CS_RUN;
          nck_cnt_reg <= 16'h0000;
        end
      endcase
    end
  end

  //============================================================
  // CKE high time and tXPDLL since the last exit, fast or slow
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cke_hi_cnt_reg <= T_CKE_NCK;
      xpdll_cnt_reg  <= T_XPDLL_NCK;
    end
    else if (launch)
    begin
      if (state_reg == dpdc_pkg::CS_PD && exit_due && !DRAM_RESET)
      begin
        cke_hi_cnt_reg <= 16'h0001;
        xpdll_cnt_reg  <= 16'h0001;
      end
      else
      begin
        if (cke_hi_cnt_reg < T_CKE_NCK && LINK.cke)
        begin
          cke_hi_cnt_reg <= cke_hi_cnt_reg + 16'h0001;
        end
        if (xpdll_cnt_reg < T_XPDLL_NCK && LINK.cke)
        begin
          xpdll_cnt_reg <= xpdll_cnt_reg + 16'h0001;
        end
      end
    end
  end

  //============================================================
  // power-down duration in system cycles
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      pd_time_reg <= 32'h0000_0000;
    end
    else if (state_reg == dpdc_pkg::CS_ENTER || state_reg == dpdc_pkg::CS_PD)
    begin
      if (pd_time_reg < PD_MAX_CYC)
      begin
        pd_time_reg <= pd_time_reg + 32'h0000_0001;
      end
    end
    else
    begin
      pd_time_reg <= 32'h0000_0000;
    end
  end

  //============================================================
  // exit kind and DLL lock at entry
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      slow_reg       <= 1'h0;
      unlocked_reg   <= 1'h0;
      NEED_DLL_RESET <= 1'h0;
    end
    else if (DRAM_RESET)
    begin
      slow_reg       <= 1'h0;
      unlocked_reg   <= 1'h0;
      NEED_DLL_RESET <= 1'h0;
    end
    else if (launch && state_reg == dpdc_pkg::CS_RUN && entry_ok && !CMD_VALID)
    begin
      slow_reg     <= SLOW_EXIT;
      unlocked_reg <= !DLL_LOCKED;
    end
    else if (launch && state_reg == dpdc_pkg::CS_EXIT)
    begin
      NEED_DLL_RESET <= unlocked_reg;
    end
    else if (DLL_LOCKED && !IN_PD)
    begin
      NEED_DLL_RESET <= 1'h0;
    end
  end

  //============================================================
  // link pins, changed at the falling link edge
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      LINK.cke     <= dpdc_pkg::DPDC_CKE_RST;
      LINK.reset_n <= dpdc_pkg::DPDC_RESET_N_RST;
      LINK.cs_n    <= 1'h1;
      LINK.ras_n   <= 1'h1;
      LINK.cas_n   <= 1'h1;
      LINK.we_n    <= 1'h1;
      LINK.odt     <= 1'h0;
    end
    else if (launch)
    begin
      LINK.reset_n <= !DRAM_RESET;
      if (state_reg == dpdc_pkg::CS_RUN && entry_ok && !CMD_VALID)
      begin
        LINK.cke <= 1'h0;
      end
      else if (state_reg == dpdc_pkg::CS_PD && exit_due)
      begin
        LINK.cke <= 1'h1;
      end
      else if (DRAM_RESET)
      begin
        LINK.cke <= 1'h1;
      end
      if (cmd_gate && CMD_VALID)
      begin
        {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= CMD_CODE;
      end
      else
      begin
        {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n} <= dpdc_pkg::DPDC_CMD_DESEL;
      end
      LINK.odt <= USER_ODT && odt_gate && state_reg == dpdc_pkg::CS_RUN;
    end
  end

  assign LINK.ck = ck_reg;

  //============================================================
  // user status
  assign CMD_TAKEN   = launch && cmd_gate && CMD_VALID;
  assign IN_PD       = state_reg != dpdc_pkg::CS_RUN;
  assign CMD_OK      = cmd_gate;
  assign DLL_CMD_OK  = cmd_gate && odt_gate && !NEED_DLL_RESET;
  assign PD_ENTRY_OK = state_reg == dpdc_pkg::CS_RUN && entry_ok;

endmodule : dpdc_controller

// >>> src/dpdc_pkg.sv
//==============================================================
package dpdc_pkg;

  //============================================================
  // clock and long timing
  localparam int unsigned DPDC_SYS_PERIOD_NS = 50;
  localparam int unsigned DPDC_T_REFI_NS     = 7800;
  localparam int unsigned DPDC_REFI_LIMIT    = 9;
  localparam int unsigned DPDC_PD_MAX_CYC    =
    (DPDC_REFI_LIMIT * DPDC_T_REFI_NS) / DPDC_SYS_PERIOD_NS;

  //============================================================
  // counts in link clock cycles; DPDC_CK_HALF_CYC in system clock cycles
  localparam int unsigned DPDC_CNT_W  = 16;
  localparam logic [15:0] DPDC_T_CKE_NCK   = 16'h0003;
  localparam logic [15:0] DPDC_T_CPDED_NCK = 16'h0001;
  localparam logic [15:0] DPDC_T_XP_NCK    = 16'h0003;
  localparam logic [15:0] DPDC_T_XPDLL_NCK = 16'h000A;
  localparam logic [15:0] DPDC_CK_HALF_CYC = 16'h0001;

  //============================================================
  // reset values
  localparam logic DPDC_CKE_RST     = 1'h1;
  localparam logic DPDC_RESET_N_RST = 1'h0;

  //============================================================
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] DPDC_CMD_DESEL = 4'hF;
  localparam logic [3:0] DPDC_CMD_NOP   = 4'h7;
  localparam logic [3:0] DPDC_CMD_REF   = 4'h1;

  //============================================================
  // states
  typedef enum logic [1:0] {CS_RUN, CS_ENTER, CS_PD, CS_EXIT} dpdc_ctrl_state_type;
  typedef enum logic [1:0] {DS_IDLE, DS_PD, DS_SREF} dpdc_dev_state_type;

endpackage : dpdc_pkg

// >>> src/dpdc_link_if.sv
`timescale 1ns/10ps
//==============================================================
// link between controller and device
interface dpdc_link_if;
  logic ck;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic reset_n;

  modport ctrl
  (
    output ck,
    output cke,
    output cs_n,
    output ras_n,
    output cas_n,
    output we_n,
    output odt,
    output reset_n
  );

  modport dev
  (
    input ck,
    input cke,
    input cs_n,
    input ras_n,
    input cas_n,
    input we_n,
    input odt,
    input reset_n
  );
endinterface : dpdc_link_if

// >>> src/dpdc_device.sv
`timescale 1ns/10ps
//==============================================================
// device end: power-down entry and exit on the link clock
module dpdc_device
#(
  parameter logic [15:0] T_CPDED_NCK = dpdc_pkg::DPDC_T_CPDED_NCK
)
(
  dpdc_link_if.dev   LINK,
  input  wire logic  BANK_OPEN,
  input  wire logic  ROW_OP_BUSY,
  input  wire logic  FAST_EXIT_A12,
  output logic       PD_ACTIVE,
  output logic       PD_PRECHARGE,
  output logic       BUF_OFF,
  output logic       CMD_RX_OFF,
  output logic       DLL_ON,
  output logic       SREF_MODE
);

  dpdc_pkg::dpdc_dev_state_type state_reg;
  logic [3:0]                   cmd;
  logic                         is_nop;
  logic [15:0]                  cpded_cnt_reg;
  logic                         settled_reg;

  assign cmd    = {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n};
  assign is_nop = LINK.cs_n | (LINK.ras_n & LINK.cas_n & LINK.we_n);

  //============================================================
  // state
  always_ff @(posedge LINK.ck or negedge LINK.reset_n)
  begin
    if (!LINK.reset_n)
    begin
      state_reg <= dpdc_pkg::DS_IDLE;
    end
    else
    begin
      case (state_reg)
        dpdc_pkg::DS_IDLE:
        begin
          if (!LINK.cke && cmd == dpdc_pkg::DPDC_CMD_REF)
          begin
            state_reg <= dpdc_pkg::DS_SREF;
          end
          else if (!LINK.cke && is_nop)
          begin
            state_reg <= dpdc_pkg::DS_PD;
          end
        end
        dpdc_pkg::DS_PD:
        begin
          if (LINK.cke)
          begin
            state_reg <= dpdc_pkg::DS_IDLE;
          end
        end
        dpdc_pkg::DS_SREF:
        begin
          if (LINK.cke)
          begin
            state_reg <= dpdc_pkg::DS_IDLE;
          end
        end
        default:
        begin
          state_reg <= dpdc_pkg::DS_IDLE;
        end
      endcase
    end
  end

  //============================================================
  // tCPDED counter and receiver shutdown
  always_ff @(posedge LINK.ck or negedge LINK.reset_n)
  begin
    if (!LINK.reset_n)
    begin
      cpded_cnt_reg <= 16'h0000;
      CMD_RX_OFF    <= 1'h0;
    end
    else if (state_reg == dpdc_pkg::DS_PD && !LINK.cke)
    begin
      if (cpded_cnt_reg < T_CPDED_NCK)
      begin
        cpded_cnt_reg <= cpded_cnt_reg + 16'h0001;
      end
      CMD_RX_OFF <= (cpded_cnt_reg + 16'h0001 >= T_CPDED_NCK);
    end
    else
    begin
      cpded_cnt_reg <= 16'h0000;
      CMD_RX_OFF    <= 1'h0;
    end
  end

  //============================================================
  // mode once in-flight row operations finish
  always_ff @(posedge LINK.ck or negedge LINK.reset_n)
  begin
    if (!LINK.reset_n)
    begin
      settled_reg  <= 1'h0;
      PD_ACTIVE    <= 1'h0;
      PD_PRECHARGE <= 1'h0;
      DLL_ON       <= 1'h1;
    end
    else if (state_reg == dpdc_pkg::DS_PD && !LINK.cke)
    begin
      if (!settled_reg && !ROW_OP_BUSY)
      begin
        settled_reg  <= 1'h1;
        PD_ACTIVE    <= BANK_OPEN;
        PD_PRECHARGE <= !BANK_OPEN;
        DLL_ON       <= BANK_OPEN | FAST_EXIT_A12;
      end
    end
    else
    begin
      settled_reg  <= 1'h0;
      PD_ACTIVE    <= 1'h0;
      PD_PRECHARGE <= 1'h0;
      DLL_ON       <= (state_reg != dpdc_pkg::DS_SREF) || LINK.cke;
    end
  end

  //============================================================
  // buffers and self-refresh flag
  always_ff @(posedge LINK.ck or negedge LINK.reset_n)
  begin
    if (!LINK.reset_n)
    begin
      BUF_OFF   <= 1'h0;
      SREF_MODE <= 1'h0;
    end
    else
    begin
      BUF_OFF   <= !LINK.cke &&
                   ((state_reg == dpdc_pkg::DS_IDLE && is_nop) ||
                    state_reg == dpdc_pkg::DS_PD);
      SREF_MODE <= !LINK.cke &&
                   ((state_reg == dpdc_pkg::DS_IDLE && cmd == dpdc_pkg::DPDC_CMD_REF) ||
                    state_reg == dpdc_pkg::DS_SREF);
    end
  end

endmodule : dpdc_device

// >>> bench/dpdc_link_monitor.sv
`timescale 1ns/10ps
//==============================================================
// link checker
module dpdc_link_monitor
#(
  parameter int unsigned PD_MAX_CYC = 40
)
(
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic reset_n
);
  // link clock is two system clocks, plus slack for exit
  localparam int unsigned PD_MAX_NCK = PD_MAX_CYC / 2 + 8;

  int unsigned low_cnt_reg;
  logic        is_idle;

  assign is_idle = cs_n || ({cs_n, ras_n, cas_n, we_n} == dpdc_pkg::DPDC_CMD_NOP);

  //============================================================
  // power-down length counter
  always_ff @(posedge ck or negedge reset_n)
    if (!reset_n)
      low_cnt_reg <= 0;
    else if (cke)
      low_cnt_reg <= 0;
    else
      low_cnt_reg <= low_cnt_reg + 1;

  default clocking cb @(posedge ck);
  endclocking
  default disable iff (!reset_n);

  sequence quiet_exit;
    is_idle [*3];
  endsequence

  sequence held_high;
    cke [*3];
  endsequence

  //============================================================
  // assertions
  chk_entry_quiet: assert property ($fell(cke) |-> is_idle)
    else $error("command with power-down entry");
  chk_cpded_quiet: assert property ($fell(cke) |=> is_idle)
    else $error("command inside entry delay");
  chk_low_min: assert property ($fell(cke) |-> !cke [*3])
    else $error("power-down too short");
  chk_high_min: assert property ($rose(cke) |-> held_high)
    else $error("clock enable high too short");
  chk_exit_quiet: assert property ($rose(cke) |-> quiet_exit)
    else $error("command before exit latency");
  chk_no_sref: assert property ($fell(cke) |-> {cs_n, ras_n, cas_n, we_n} != 4'h1)
    else $error("self-refresh code at entry");
  chk_odt_low: assert property (!cke && !$past(cke) |-> !odt)
    else $error("termination driven in power-down");
  chk_pd_bound: assert property (low_cnt_reg <= PD_MAX_NCK)
    else $error("power-down lasts too long");
endmodule : dpdc_link_monitor

// >>> bench/test_ddr3_power_down_control.sv
`timescale 1ns/10ps
`define CHK(nm, got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module test_ddr3_power_down_control;
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic       pd_req = 1'b0;
  logic       blocking_busy = 1'b0;
  logic       dll_locked = 1'b1;
  logic       slow_exit = 1'b0;
  logic       dram_reset = 1'b0;
  logic       cmd_valid = 1'b0;
  logic [3:0] cmd_code = 4'hF;
  logic       user_odt = 1'b1;
  logic       bank_open = 1'b0;
  logic       row_op_busy = 1'b0;
  logic       fast_exit_a12 = 1'b0;
  logic       cmd_taken, in_pd, cmd_ok, dll_cmd_ok, pd_entry_ok, need_dll_reset;
  logic       pd_active, pd_precharge, buf_off, cmd_rx_off, dll_on, sref_mode;
  int         errors = 0;
  int         comparisons = 0;
  logic [3:0] exp_q[$];
  logic [3:0] want;
  logic [3:0] flags;
  logic [3:0] code_tab [3] = '{4'h3, 4'h2, 4'h1};

  assign flags = {dll_cmd_ok, buf_off, cmd_ok, in_pd};

  always #25 sys_clk = ~sys_clk;

  dpdc_link_if link ();

  dpdc_controller #(.PD_MAX_CYC(40)) i_dpdc_controller
  (
    .SYS_CLK(sys_clk), .RESET(reset), .LINK(link), .PD_REQ(pd_req),
    .BLOCKING_BUSY(blocking_busy), .DLL_LOCKED(dll_locked), .SLOW_EXIT(slow_exit),
    .DRAM_RESET(dram_reset), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
    .USER_ODT(user_odt), .CMD_TAKEN(cmd_taken), .IN_PD(in_pd), .CMD_OK(cmd_ok),
    .DLL_CMD_OK(dll_cmd_ok), .PD_ENTRY_OK(pd_entry_ok), .NEED_DLL_RESET(need_dll_reset)
  );

  dpdc_device i_dpdc_device
  (
    .LINK(link), .BANK_OPEN(bank_open), .ROW_OP_BUSY(row_op_busy),
    .FAST_EXIT_A12(fast_exit_a12), .PD_ACTIVE(pd_active), .PD_PRECHARGE(pd_precharge),
    .BUF_OFF(buf_off), .CMD_RX_OFF(cmd_rx_off), .DLL_ON(dll_on), .SREF_MODE(sref_mode)
  );

  dpdc_link_monitor #(.PD_MAX_CYC(40)) i_dpdc_link_monitor
  (
    .ck(link.ck), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .odt(link.odt), .reset_n(link.reset_n)
  );

  //============================================================
  // command watcher: compares link commands with the queue
  always @(posedge link.ck)
  begin
    if (link.reset_n === 1'b1 && link.cs_n === 1'b0 &&
        {link.ras_n, link.cas_n, link.we_n} !== 3'h7)
    begin
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hF;
      `CHK("link command", {link.cs_n, link.ras_n, link.cas_n, link.we_n}, want)
    end
  end

  //============================================================
  // tasks
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic wait_flag(input int idx, input logic val, input int bound);
    int n;
    for (n = 0; n < bound && flags[idx] !== val; n++)
      @(negedge sys_clk);
    if (flags[idx] !== val)
    begin
      errors++;
      $display("ERROR wait on flag %0d expected %0h seen %0h", idx, val, flags[idx]);
      tally_and_finish();
    end
  endtask : wait_flag

  task automatic send_cmd(input logic [3:0] code);
    int n;
    cmd_code  = code;
    cmd_valid = 1'b1;
    exp_q.push_back(code);
    #1;
    for (n = 0; n < 40 && cmd_taken !== 1'b1; n++)
    begin
      @(negedge sys_clk);
      #1;
    end
    `CHK("command taken", cmd_taken, 1'b1)
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask : send_cmd

  task automatic pd_cycle(input int i);
    bank_open     = i[0];
    fast_exit_a12 = i[1];
    slow_exit     = ~i[0] & ~i[1];
    row_op_busy   = i[2];
    dll_locked    = (i != 7);
    blocking_busy = (i == 3);
    user_odt      = 1'($urandom_range(1, 0));
    pd_req        = 1'b1;
    if (i == 3)
    begin
      repeat (10) @(negedge sys_clk);
      `CHK("entry while busy", in_pd, 1'b0)
      blocking_busy = 1'b0;
    end
    wait_flag(0, 1'b1, 60);
    wait_flag(2, 1'b1, 20);
    repeat (6) @(negedge sys_clk);
    `CHK("receivers off", cmd_rx_off, 1'b1)
    `CHK("self-refresh mode", sref_mode, 1'b0)
    if (i[2])
    begin
      `CHK("mode while row busy", pd_active | pd_precharge, 1'b0)
      row_op_busy = 1'b0;
      repeat (6) @(negedge sys_clk);
    end
    `CHK("active mode", pd_active, i[0])
    `CHK("precharge mode", pd_precharge, ~i[0])
    `CHK("dll state", dll_on, i[0] | i[1])
    if (i != 6)
      pd_req = 1'b0;
    wait_flag(0, 1'b0, 120);
    pd_req = 1'b0;
    `CHK("command ok early", cmd_ok, 1'b0)
    wait_flag(1, 1'b1, 20);
    `CHK("dll reset owed", need_dll_reset, ~dll_locked)
    `CHK("dll command ok", dll_cmd_ok, ~slow_exit & dll_locked)
    `CHK("termination gate", link.odt, user_odt & ~slow_exit & dll_locked)
    if (slow_exit)
    begin
      `CHK("dll command ok early", dll_cmd_ok, 1'b0)
      pd_req = 1'b1;
      #1;
      `CHK("re-entry early", pd_entry_ok, 1'b0)
      @(negedge sys_clk);
      pd_req = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    `CHK("buffers back on", buf_off, 1'b0)
    send_cmd(code_tab[$urandom_range(2, 0)]);
  endtask : pd_cycle

  //============================================================
  // main sequence
  initial
  begin
    void'($urandom(34));
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    for (int i = 0; i < 8; i++)
      pd_cycle(i);
    dll_locked = 1'b1;
    pd_req     = 1'b1;
    wait_flag(0, 1'b1, 60);
    repeat (6) @(negedge sys_clk);
    dram_reset = 1'b1;
    wait_flag(0, 1'b0, 20);
    repeat (4) @(negedge sys_clk);
    `CHK("reset leaves power-down", pd_active | pd_precharge | buf_off, 1'b0)
    dram_reset = 1'b0;
    pd_req     = 1'b0;
    repeat (10) @(negedge sys_clk);
    `CHK("commands all seen", exp_q.size() == 0, 1'b1)
    tally_and_finish();
  end

  initial
  begin
    repeat (100000) @(negedge sys_clk);
    errors++;
    $display("ERROR run limit expected 0 seen 1");
    tally_and_finish();
  end
endmodule : test_ddr3_power_down_control
